//--- core/camera_sync_code_framer.sv
// camera sync code framer: frame and line code insertion on the pixel stream
`timescale 1ns/100ps
`include "framer_consts.svh"

module camera_sync_code_framer (
  // clock and reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     rstn_i,
  // camera side, sampled on pixel enable
  input  wire logic                     pix_en_i,
  input  wire logic [7:0]               pixel_data_i,
  input  wire logic                     frame_valid_in_i,
  input  wire logic                     line_valid_in_i,
  input  wire logic                     predict_mode_i,
  // byte stream to the serializer
  output logic                          out_valid_o,
  output logic [7:0]                    out_byte_o,
  input  wire logic                     out_ready_i,
  // status
  output logic [`LINE_CNT_W-1:0]        line_total_o,
  output logic                          overflow_o
);
  import framer_pkg::*;

  typedef struct packed {
    frame_state_type           state;
    logic                      fv_prev;
    logic                      lv_prev;
    logic [`LINE_CNT_W-1:0]    line_cnt;
    logic [`LINE_CNT_W-1:0]    line_total;
    logic                      overflow;
    logic [2:0]                code_idx;
  } framer_state_type;

  localparam framer_state_type RESET_STATE = '{
    state: st_blank, fv_prev: 1'b0, lv_prev: 1'b0,
    line_cnt: `LINE_CNT_ZERO, line_total: `LINE_CNT_ZERO,
    overflow: 1'b0, code_idx: 3'h0};

  framer_state_type state_reg;
  framer_state_type state_next;
  logic             fv_rise;
  logic             fv_fall;
  logic             lv_rise;
  logic             lv_fall;
  logic             predict_end;
  logic             push_valid;
  item_type         push_item;
  logic             buf_in_ready;
  logic             head_valid;
  item_type         head_item;
  logic             head_pop;
  logic             flt_in_valid;
  logic [7:0]       flt_in_byte;
  logic             flt_in_is_code;
  logic             flt_in_ready;
  logic [31:0]      code_word;

  // ------------------------------------------------------------
  // edge detection on the pixel enable
  // ------------------------------------------------------------
  assign fv_rise = pix_en_i && frame_valid_in_i && !state_reg.fv_prev;
  assign fv_fall = pix_en_i && !frame_valid_in_i && state_reg.fv_prev;
  assign lv_rise = pix_en_i && line_valid_in_i && !state_reg.lv_prev;
  assign lv_fall = pix_en_i && !line_valid_in_i && state_reg.lv_prev;
  // a zero total never predicts, so the first frame ends on frame valid
  assign predict_end = predict_mode_i && (state_reg.line_total != `LINE_CNT_ZERO)
                       && (state_reg.line_cnt == state_reg.line_total);

  // ------------------------------------------------------------
  // framer and output stage next state
  // ------------------------------------------------------------
  // a code pushed on a line rise carries that cycle's pixel with it
  always_comb begin
    state_next = state_reg;
    push_valid = 1'b0;
    push_item  = '0;
    push_item.data = pixel_data_i;
    if (pix_en_i) begin
      state_next.fv_prev = frame_valid_in_i;
      state_next.lv_prev = line_valid_in_i;
      if (predict_mode_i && frame_valid_in_i && lv_rise) begin
        state_next.line_cnt = state_reg.line_cnt + `LINE_CNT_ONE;
      end
      if (fv_fall) begin
        state_next.line_total = state_reg.line_cnt;
        state_next.line_cnt   = `LINE_CNT_ZERO;
      end
      case (state_reg.state)
        st_blank: begin
          if (fv_rise && lv_rise) begin
            push_valid = 1'b1;
            push_item.is_code   = 1'b1;
            push_item.has_pixel = 1'b1;
            push_item.kind      = frame_start_kind;
            state_next.state    = st_line;
          end else if (fv_rise) begin
            state_next.state = st_wait_line;
          end
        end
        st_wait_line: begin
          if (!frame_valid_in_i) begin
            state_next.state = st_blank;
          end else if (lv_rise) begin
            push_valid = 1'b1;
            push_item.is_code   = 1'b1;
            push_item.has_pixel = 1'b1;
            push_item.kind      = frame_start_kind;
            state_next.state    = st_line;
          end
        end
        st_gap: begin
          if (!frame_valid_in_i) begin
            push_valid = 1'b1;
            push_item.is_code = 1'b1;
            push_item.kind    = frame_end_kind;
            state_next.state  = st_blank;
          end else if (lv_rise) begin
            push_valid = 1'b1;
            push_item.is_code   = 1'b1;
            push_item.has_pixel = 1'b1;
            push_item.kind      = line_start_kind;
            state_next.state    = st_line;
          end
        end
        st_line: begin
          if (lv_fall || !frame_valid_in_i) begin
            push_valid = 1'b1;
            push_item.is_code = 1'b1;
            if (!frame_valid_in_i) begin
              push_item.kind   = frame_end_kind;
              state_next.state = st_blank;
            end else if (predict_end) begin
              push_item.kind   = frame_end_kind;
              state_next.state = st_discard;
            end else begin
              push_item.kind   = line_end_kind;
              state_next.state = st_gap;
            end
          end else begin
            push_valid = 1'b1;
          end
        end
        st_discard: begin
          // extra lines after an early frame end are blanked
          if (!frame_valid_in_i) begin
            state_next.state = st_blank;
          end
        end
        default: begin
          state_next.state = st_blank;
        end
      endcase
      // the camera cannot be stalled, so a full buffer is only reported
      if (push_valid && !buf_in_ready) begin
        state_next.overflow = 1'b1;
      end
    end
    // walk the code bytes at the buffer head
    if (flt_in_valid && flt_in_ready && head_item.is_code && !head_pop) begin
      state_next.code_idx = state_reg.code_idx + `IDX_ONE;
    end else if (head_pop) begin
      state_next.code_idx = 3'h0;
    end
  end

  // state register, counters clear at reset
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // code expansion into bytes
  // ------------------------------------------------------------
  always_comb begin
    case (head_item.kind)
      line_start_kind:  code_word = `LINE_START_WORD;
      line_end_kind:    code_word = `LINE_END_WORD;
      frame_start_kind: code_word = `FRAME_START_WORD;
      frame_end_kind:   code_word = `FRAME_END_WORD;
      default:          code_word = `LINE_START_WORD;
    endcase
  end

  // top byte first, so the code opens with the ones and zeros prefix;
  // the carried pixel follows the kind byte
  assign flt_in_valid   = head_valid;
  assign flt_in_is_code = head_item.is_code && (state_reg.code_idx != `PIXEL_IDX);
  assign flt_in_byte    = !flt_in_is_code ? head_item.data
                          : code_word[{~state_reg.code_idx[1:0], 3'h0} +: 8];
  assign head_pop = flt_in_valid && flt_in_ready
                    && (!head_item.is_code
                        || (state_reg.code_idx == `PIXEL_IDX)
                        || (state_reg.code_idx == `LAST_CODE_IDX && !head_item.has_pixel));

  item_buffer u_item_buffer (
    .ref_clk_i   (ref_clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (push_valid),
    .in_item_i   (push_item),
    .in_ready_o  (buf_in_ready),
    .out_valid_o (head_valid),
    .out_item_o  (head_item),
    .out_ready_i (head_pop)
  );

  escape_filter u_escape_filter (
    .ref_clk_i    (ref_clk_i),
    .rstn_i       (rstn_i),
    .in_valid_i   (flt_in_valid),
    .in_byte_i    (flt_in_byte),
    .in_is_code_i (flt_in_is_code),
    .in_ready_o   (flt_in_ready),
    .out_valid_o  (out_valid_o),
    .out_byte_o   (out_byte_o),
    .out_ready_i  (out_ready_i)
  );

  assign line_total_o = state_reg.line_total;
  assign overflow_o   = state_reg.overflow;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sof_first_line_a: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (lv_rise && frame_valid_in_i && (state_reg.state == st_wait_line || fv_rise))
    |-> (push_valid && push_item.is_code && push_item.kind == frame_start_kind))
    else $error("frame start not sent on first line");
  sol_next_line_a: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (state_reg.state == st_gap && lv_rise && frame_valid_in_i)
    |-> (push_valid && push_item.kind == line_start_kind) ##1 state_reg.state == st_line)
    else $error("line start not sent");
  eol_line_fall_a: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (state_reg.state == st_line && lv_fall && frame_valid_in_i && !predict_end)
    |-> (push_valid && push_item.kind == line_end_kind))
    else $error("line end not sent");
  eof_joint_fall_a: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (state_reg.state == st_line && lv_fall && fv_fall)
    |-> (push_valid && push_item.kind == frame_end_kind) ##1 state_reg.state == st_blank)
    else $error("frame end not sent on joint fall");
  cnt_step_a: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (predict_mode_i && lv_rise && frame_valid_in_i)
    |=> state_reg.line_cnt == $past(state_reg.line_cnt) + `LINE_CNT_ONE)
    else $error("line counter did not step");
  total_latch_a: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    fv_fall |=> (state_reg.line_total == $past(state_reg.line_cnt)
                 && state_reg.line_cnt == `LINE_CNT_ZERO))
    else $error("line total not latched");
  predict_eof_a: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (state_reg.state == st_line && lv_fall && frame_valid_in_i && predict_end)
    |-> push_item.kind == frame_end_kind ##1 state_reg.state == st_discard)
    else $error("predicted frame end missing");
  discard_blank_a: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    state_reg.state == st_discard |-> !push_valid)
    else $error("data pushed while discarding");
  gap_frame_end_a: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (state_reg.state == st_gap && pix_en_i && !frame_valid_in_i)
    |-> (push_valid && push_item.kind == frame_end_kind) ##1 state_reg.state == st_blank)
    else $error("frame end not sent after line end");
  wait_first_line_a: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (state_reg.state == st_blank && fv_rise && !lv_rise) |=> state_reg.state == st_wait_line)
    else $error("frame start edge not taken");
  code_kind_last_a: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (flt_in_valid && flt_in_is_code && state_reg.code_idx == `LAST_CODE_IDX)
    |-> flt_in_byte == {6'h00, head_item.kind})
    else $error("code kind byte not sent last");
  overflow_sticky_a: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    state_reg.overflow |=> state_reg.overflow)
    else $error("overflow flag dropped");
endmodule

//--- core/framer_consts.svh
// constants for the camera sync code framer
`ifndef FRAMER_CONSTS_SVH
`define FRAMER_CONSTS_SVH

// sync code words, top byte first so the run of ones leads
`define LINE_START_WORD  32'hFF00_0000
`define LINE_END_WORD    32'hFF00_0001
`define FRAME_START_WORD 32'hFF00_0002
`define FRAME_END_WORD   32'hFF00_0003

// line counter width, enough for 2047 active lines
`define LINE_CNT_W       11
`define LINE_CNT_ONE     11'h001
`define LINE_CNT_ZERO    11'h000

// byte values
`define IDLE_BYTE        8'hFF
`define ZERO_BYTE        8'h00
`define ESCAPED_BYTE     8'h01

// code byte walk: four code bytes, then the optional carried pixel
`define LAST_CODE_IDX    3'h3
`define PIXEL_IDX        3'h4
`define IDX_ONE          3'h1

`endif

//--- core/framer_pkg.sv
// types shared by the camera sync code framer modules
package framer_pkg;
  `include "framer_consts.svh"

  typedef enum logic [1:0] {
    line_start_kind  = 2'h0,
    line_end_kind    = 2'h1,
    frame_start_kind = 2'h2,
    frame_end_kind   = 2'h3
  } sync_kind_type;

  // one buffered item: a pixel, or a code optionally followed by a pixel
  typedef struct packed {
    logic          is_code;
    logic          has_pixel;
    sync_kind_type kind;
    logic [7:0]    data;
  } item_type;

  typedef enum logic [4:0] {
    st_blank     = 5'b00001,
    st_wait_line = 5'b00010,
    st_gap       = 5'b00100,
    st_line      = 5'b01000,
    st_discard   = 5'b10000
  } frame_state_type;
endpackage

//--- core/item_buffer.sv
// two-entry item buffer between the framer and the byte output stage
`timescale 1ns/100ps
module item_buffer
  import framer_pkg::*;
(
  // clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                rstn_i,
  // filling side
  input  wire logic                in_valid_i,
  input  wire framer_pkg::item_type in_item_i,
  output logic                     in_ready_o,
  // draining side
  output logic                     out_valid_o,
  output framer_pkg::item_type     out_item_o,
  input  wire logic                out_ready_i
);
  import framer_pkg::*;

  typedef struct packed {
    item_type [1:0] slot;
    logic           wr_ptr;
    logic           rd_ptr;
    logic [1:0]     count;
  } buf_state_type;

  buf_state_type state_reg;
  buf_state_type state_next;
  logic          push;
  logic          pop;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // full and empty come straight from the count, so they never lie
  always_comb begin
    state_next = state_reg;
    push = in_valid_i && (state_reg.count != 2'h2);
    pop  = out_ready_i && (state_reg.count != 2'h0);
    if (push) begin
      state_next.slot[state_reg.wr_ptr] = in_item_i;
      state_next.wr_ptr = ~state_reg.wr_ptr;
    end
    if (pop) begin
      state_next.rd_ptr = ~state_reg.rd_ptr;
    end
    if (push && !pop) begin
      state_next.count = state_reg.count + 2'h1;
    end else if (pop && !push) begin
      state_next.count = state_reg.count - 2'h1;
    end
  end

  // state register
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign in_ready_o  = (state_reg.count != 2'h2);
  assign out_valid_o = (state_reg.count != 2'h0);
  assign out_item_o  = state_reg.slot[state_reg.rd_ptr];
endmodule

//--- core/escape_filter.sv
// output stage that breaks any pixel imitation of the sync prefix
`timescale 1ns/100ps
`include "framer_consts.svh"
module escape_filter (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  // byte input
  input  wire logic       in_valid_i,
  input  wire logic [7:0] in_byte_i,
  input  wire logic       in_is_code_i,
  output logic            in_ready_o,
  // byte output
  output logic            out_valid_o,
  output logic [7:0]      out_byte_o,
  input  wire logic       out_ready_i
);
  import framer_pkg::*;

  // history holds the last two bytes as sent, corrections included
  typedef struct packed {
    logic [7:0] prev2;
    logic [7:0] prev1;
    logic [7:0] out_byte;
    logic       out_valid;
  } flt_state_type;

  localparam flt_state_type RESET_STATE = '{
    prev2: `ZERO_BYTE, prev1: `ZERO_BYTE, out_byte: `IDLE_BYTE, out_valid: 1'b0};

  flt_state_type state_reg;
  flt_state_type state_next;
  logic [7:0]    hit;
  logic          fix;
  logic          take;

  // ------------------------------------------------------------
  // pattern match, one term per alignment of the run of ones
  // ------------------------------------------------------------
  // j ones sit at the low end of prev1, the rest at the top of prev2
  for (genvar j = 0; j < 8; j++) begin : g_align
    localparam logic [7:0] LOW_ONES = 8'((16'h0001 << j) - 16'h0001);
    assign hit[j] = (state_reg.prev1 == LOW_ONES) && (&state_reg.prev2[7:j]);
  end
  assign fix = !in_is_code_i && (in_byte_i == `ZERO_BYTE) && (|hit);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    take = in_valid_i && (!state_reg.out_valid || out_ready_i);
    if (take) begin
      state_next.out_valid = 1'b1;
      state_next.out_byte  = fix ? `ESCAPED_BYTE : in_byte_i;
      state_next.prev2     = state_reg.prev1;
      state_next.prev1     = state_next.out_byte;
    end else if (out_ready_i) begin
      // nothing to send: line held high
      state_next.out_valid = 1'b0;
      state_next.out_byte  = `IDLE_BYTE;
    end
  end

  // state register
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign in_ready_o  = !state_reg.out_valid || out_ready_i;
  assign out_valid_o = state_reg.out_valid;
  assign out_byte_o  = state_reg.out_byte;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  escape_fix_a: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (take && !in_is_code_i && in_byte_i == `ZERO_BYTE && state_reg.prev2 == `IDLE_BYTE
     && state_reg.prev1 == `ZERO_BYTE) |=> (out_valid_o && out_byte_o == `ESCAPED_BYTE))
    else $error("zero byte after prefix not escaped");
  idle_high_a: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !out_valid_o |-> out_byte_o == `IDLE_BYTE)
    else $error("idle output not held high");
endmodule

//--- test/byte_receiver_model.sv
// far-side receiver model: paces ready and reports accepted bytes
`timescale 1ns/100ps
module byte_receiver_model (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  // pacing: 0 prompt, 1 every other cycle, 2 stalled
  input  wire logic [1:0] mode_i,
  // byte stream from the framer
  input  wire logic       out_valid_i,
  input  wire logic [7:0] out_byte_i,
  output logic            ready_o,
  // accepted bytes, one cycle after the transfer
  output logic            rx_stb_o,
  output logic [7:0]      rx_byte_o
);
  logic phase_reg = 1'b0;

  // ready moves on the falling edge so it never races the sampling edge
  initial ready_o = 1'b0;
  always @(negedge ref_clk_i) begin
    phase_reg <= ~phase_reg & rstn_i;
    ready_o   <= (mode_i == 2'h0) || (mode_i == 2'h1 && phase_reg);
  end

  // a byte counts only where valid and ready meet at a rising edge
  always @(posedge ref_clk_i) begin
    rx_stb_o  <= out_valid_i && ready_o && rstn_i;
    rx_byte_o <= out_byte_i;
  end
endmodule

//--- test/camera_sync_code_framer_test.sv
// self-checking bench for the camera sync code framer
`timescale 1ns/100ps
`include "framer_consts.svh"
module camera_sync_code_framer_test;
  import framer_pkg::*;
  logic                   clk     = 1'b0;
  logic                   rstn    = 1'b0;
  logic                   pix_en  = 1'b0;
  logic                   fv      = 1'b0;
  logic                   lv      = 1'b0;
  logic                   predict = 1'b0;
  logic                   free    = 1'b0;
  logic [7:0]             px      = 8'h00;
  logic [1:0]             pace    = 2'h0;
  logic [15:0]            hist    = 16'h0000;
  logic                   ready, rx_stb, valid, ovf;
  logic [7:0]             rx_byte, obyte;
  logic [`LINE_CNT_W-1:0] total;
  logic [7:0]             exp_q[$];
  logic [7:0]             pq[$];
  int                     errors = 0;
  int                     check_count = 0;

  initial forever #10 clk = ~clk;

  camera_sync_code_framer dut (
    .ref_clk_i(clk), .rstn_i(rstn), .pix_en_i(pix_en), .pixel_data_i(px),
    .frame_valid_in_i(fv), .line_valid_in_i(lv), .predict_mode_i(predict),
    .out_valid_o(valid), .out_byte_o(obyte), .out_ready_i(ready),
    .line_total_o(total), .overflow_o(ovf));

  byte_receiver_model partner (
    .ref_clk_i(clk), .rstn_i(rstn), .mode_i(pace), .out_valid_i(valid),
    .out_byte_i(obyte), .ready_o(ready), .rx_stb_o(rx_stb), .rx_byte_o(rx_byte));

  // ------------------------------
  // checking and expectations
  // ------------------------------
  task check(input string what, input logic [10:0] e, input logic [10:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask

  task test_done();
    $display("checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // hist holds the last two bytes sent, newest in the upper half
  task push(input logic [7:0] b, input logic is_code);
    logic hit;
    hit = 1'b0;
    for (int s = 0; s < 8; s++) hit |= ((hist >> s) == 16'h00FF);
    if (!is_code && b === 8'h00 && hit) b = 8'h01;
    exp_q.push_back(b);
    hist = {b, hist[15:8]};
  endtask

  // code word goes out top byte first, so it opens with eight ones
  task code(input logic [1:0] k);
    push(8'hFF, 1'b1);
    push(8'h00, 1'b1);
    push(8'h00, 1'b1);
    push({6'h00, k}, 1'b1);
  endtask

  // every received byte while free is low is matched against the oldest note
  always @(posedge clk) begin
    if (rx_stb && !free) begin
      if (exp_q.size() == 0) check("extra byte", 11'h7FF, {3'h0, rx_byte});
      else check("byte", {3'h0, exp_q.pop_front()}, {3'h0, rx_byte});
    end
    if (rstn && valid !== 1'b1) check("idle byte", 11'h0FF, {3'h0, obyte});
  end

  // ------------------------------
  // camera stimulus
  // ------------------------------
  function automatic logic [7:0] rnd();
    return ($urandom_range(0, 2) == 0) ? 8'h00 : 8'($urandom);
  endfunction

  // one pixel sample, spaced so a receiver ready every other cycle loses nothing
  task smp(input logic f, input logic l, input logic [7:0] p);
    @(negedge clk);
    {pix_en, fv, lv, px} = {1'b1, f, l, p};
    @(negedge clk);
    pix_en = 1'b0;
    repeat (10) @(negedge clk);
  endtask

  task drain();
    int t;
    t = 0;
    while (exp_q.size() > 0 && t < 3000) begin
      @(negedge clk);
      t++;
    end
    if (exp_q.size() > 0) begin
      errors++;
      $display("unexpected pending bytes: expected 0, seen %0d", exp_q.size());
      test_done();
    end
  endtask

  // notes go in before each sample since bytes leave two edges later
  task line(input sync_kind_type sk, input logic fe, input logic keep, input logic [2:0] ek);
    logic [7:0] p;
    int n;
    n = (pq.size() > 0) ? pq.size() : 3;
    for (int i = 0; i < n; i++) begin
      p = (pq.size() > 0) ? pq.pop_front() : rnd();
      if (keep && i == 0) code(sk);
      if (keep) push(p, 1'b0);
      smp(1'b1, 1'b1, p);
    end
    if (ek[2]) code(ek[1:0]);
    smp(fe, 1'b0, rnd());
  endtask

  // ne: line where a predicted frame end falls, 0 for none
  task frame(input int nl, input int ne, input logic joint, input logic lead);
    logic keep;
    if (lead) smp(1'b1, 1'b0, rnd());
    for (int l = 1; l <= nl; l++) begin
      keep = (ne == 0) || (l <= ne);
      line(l == 1 ? frame_start_kind : line_start_kind, !(joint && l == nl), keep,
           !keep ? 3'h0 : (l == ne || (joint && l == nl)) ? {1'b1, frame_end_kind}
                                                         : {1'b1, line_end_kind});
      if (l < nl) smp(1'b1, 1'b0, rnd());
    end
    if (!joint && ne == 0) code(frame_end_kind);
    if (!joint) smp(1'b0, 1'b0, rnd());
    smp(1'b0, 1'b0, rnd());
    drain();
  endtask

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    void'($urandom(4));
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    // prediction off, receiver always ready; a joint fall sends frame end without line end
    frame(3, 0, 1'b1, 1'b0);
    check("line total", 11'h000, total);
    frame(2, 0, 1'b0, 1'b1);
    $display("done: frames without prediction");
    pq = '{8'hFE, 8'h01, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
    frame(1, 0, 1'b1, 1'b0);
    $display("done: pixel escape");
    // prediction on, receiver pacing every other cycle
    pace = 2'h1;
    predict = 1'b1;
    frame(3, 0, 1'b0, 1'b1);
    check("line total", 11'h003, total);
    frame(3, 3, 1'b0, 1'b0);
    check("line total", 11'h003, total);
    frame(4, 3, 1'b0, 1'b1);
    check("line total", 11'h004, total);
    frame(2, 0, 1'b0, 1'b0);
    check("line total", 11'h002, total);
    $display("done: predicted frame end");
    // stalled receiver, samples back to back until the buffer refuses
    pace = 2'h2;
    free = 1'b1;
    @(negedge clk);
    {pix_en, fv, lv} = 3'b111;
    for (int i = 0; i < 40 && ovf !== 1'b1; i++) begin
      px = 8'($urandom);
      @(negedge clk);
    end
    pix_en = 1'b0;
    check("overflow", 11'h001, {10'h000, ovf});
    pace = 2'h0;
    repeat (40) @(negedge clk);
    check("overflow kept", 11'h001, {10'h000, ovf});
    check("drained", 11'h000, {10'h000, valid});
    $display("done: buffer overflow");
    // second reset in mid-run clears the stored total
    rstn = 1'b0;
    repeat (4) @(negedge clk);
    check("overflow", 11'h000, {10'h000, ovf});
    check("line total", 11'h000, total);
    rstn = 1'b1;
    // first frame after reset must end on frame valid, not on a stale total
    hist = 16'h0000;
    free = 1'b0;
    frame(2, 0, 1'b0, 1'b0);
    check("line total", 11'h002, total);
    $display("done: second reset");
    test_done();
  end
endmodule
